// >>> hw/arc_unit.sv
/*
  Post-conversion computation unit: accumulator, filter, error and threshold test.
  Assumes the converter core runs on ref_clk, takes conv_start as a one-cycle
  request and answers with a one-cycle conv_done beside a valid conv_result.
*/
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "arc_consts.svh"

module arc_unit (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire arc_pkg::arc_addr_t reg_addr,
  input  wire arc_pkg::arc_word_t reg_wdata,
  input  wire logic             reg_we,
  input  wire logic             reg_re,
  output arc_pkg::arc_word_t    reg_rdata,
  input  wire logic             ext_trigger,
  output logic                  conv_start,
  input  wire logic             conv_done,
  input  wire arc_pkg::arc_res_t conv_result,
  output logic                  channel_threshold_irq
);
  import arc_pkg::*;

  arc_state_t         state_q;
  logic               go_q, auto_repeat_enable_q, soi_q, double_sample_enable_q, previous_source_select_q, sub_q;
  logic               clr_req_q;
  logic [2:0]         clr_cnt_q;
  logic [2:0]         mode_q, shift_q, error_select_a_q, tmd_q;
  logic [7:0]         rpt_q, cnt_q;
  logic [15:0]        setpt_q, uth_q, lth_q;
  logic               ovf_q, first_q, upper_cross_status_q, lower_cross_status_q, flag_q;
  logic [17:0]        acc_q, flt_q, prev_q, err_q;
  logic [9:0]         res_q, hold_q;
  arc_word_t          reg_rdata_q;
  arc_word_t          rd_c;

  logic               wr_ctrl, wr_mode, wr_stat;
  logic               done, first_smp, filt_mode, restart, clr_fire;
  logic [17:0]        acc_base, acc_d_c, flt_c, flt_use;
  logic [7:0]         cnt_base, cnt_c;
  logic [18:0]        acc_sum;
  logic               ovf_hit, ovf_next, eval, cond, hit, keep_go;
  logic signed [18:0] e_res, e_flt, e_set, e_s1, err_c, e_uth, e_lth;
  logic               above_u, below_l;

  assign wr_ctrl = reg_we && (reg_addr == `ARC_OFF_CTRL);
  assign wr_mode = reg_we && (reg_addr == `ARC_OFF_MODE);
  assign wr_stat = reg_we && (reg_addr == `ARC_OFF_STAT);

  // conversions start only while idle and no clear is running
  assign conv_start = (state_q == ARC_IDLE) && !clr_req_q && (go_q || ext_trigger);
  assign done       = (state_q == ARC_CONV) && conv_done;
  assign first_smp  = double_sample_enable_q && !first_q;
  assign filt_mode  = (mode_q != `ARC_MD_BASIC);
  assign clr_fire   = clr_req_q && (clr_cnt_q == `ARC_CLR_CYCLES - 3'h1);

  // average modes start a fresh batch once the previous one is complete
  assign restart  = ((mode_q == `ARC_MD_AVG) || (mode_q == `ARC_MD_BURST)) && (cnt_q >= rpt_q);
  assign acc_base = restart ? 18'h00000 : acc_q;
  assign cnt_base = restart ? 8'h00 : cnt_q;

  // accumulator arithmetic, one spare bit catches overflow
  always_comb begin
    if (mode_q == `ARC_MD_LPF) begin
      acc_sum = {1'b0, acc_q} - {1'b0, (acc_q >> shift_q)} + {9'h000, conv_result};
    end else if (sub_q) begin
      acc_sum = {1'b0, acc_base} - {9'h000, conv_result};
    end else begin
      acc_sum = {1'b0, acc_base} + {9'h000, conv_result};
    end
  end

  assign acc_d_c  = acc_sum[17:0];
  assign ovf_hit  = filt_mode && acc_sum[18];
  assign ovf_next = ovf_q || ovf_hit;
  assign flt_c    = acc_d_c >> shift_q;
  assign flt_use  = filt_mode ? flt_c : flt_q;
  assign cnt_c    = (cnt_base == `ARC_CNT_MAX) ? `ARC_CNT_MAX : cnt_base + 8'h01;

  // basic and accumulate test every sample, the averaging modes only a full batch
  always_comb begin
    if (first_smp) begin
      eval = 1'b0;
    end else if ((mode_q == `ARC_MD_BASIC) || (mode_q == `ARC_MD_ACCUM)) begin
      eval = 1'b1;
    end else begin
      eval = (cnt_c >= rpt_q);
    end
  end

  // error operands widened to 19 signed bits; only filtered minus setpoint can still wrap
  assign e_res = $signed({9'h000, conv_result});
  assign e_flt = $signed({1'b0, flt_use});
  assign e_set = $signed({{3{setpt_q[15]}}, setpt_q});
  assign e_s1  = $signed({9'h000, (double_sample_enable_q ? hold_q : res_q)});
  assign e_uth = $signed({{3{uth_q[15]}}, uth_q});
  assign e_lth = $signed({{3{lth_q[15]}}, lth_q});

  always_comb begin
    case (error_select_a_q)
      3'h0:    err_c = e_res - $signed({9'h000, res_q});
      3'h1:    err_c = e_res - e_s1;
      3'h2:    err_c = e_res - e_set;
      3'h3:    err_c = e_res - e_flt;
      3'h4:    err_c = e_flt - $signed({1'b0, flt_q});
      3'h5:    err_c = e_flt - e_set;
      default: err_c = 19'sh00000;
    endcase
  end

  assign above_u = (err_c > e_uth);
  assign below_l = (err_c < e_lth);

  always_comb begin
    case (tmd_q)
      3'h0:    cond = 1'b0;
      3'h1:    cond = below_l;
      3'h2:    cond = !below_l;
      3'h3:    cond = !below_l && !above_u;
      3'h4:    cond = below_l || above_u;
      3'h5:    cond = !above_u;
      3'h6:    cond = above_u;
      3'h7:    cond = 1'b1;
      default: cond = 1'b0;
    endcase
  end

  // overflow forces the interrupt on any sample that runs the threshold test, so handlers can spot a bad batch
  assign hit = eval && (cond || ovf_next);

  // burst mode keeps going until its batch is full
  assign keep_go = (auto_repeat_enable_q || ((mode_q == `ARC_MD_BURST) && (cnt_c < rpt_q)))
                   && !(soi_q && hit);

  // conversion handshake
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ARC_IDLE;
    end else begin
      case (state_q)
        ARC_IDLE: begin
          if (conv_start) begin
            state_q <= ARC_CONV;
          end
        end
        ARC_CONV: begin
          if (conv_done) begin
            state_q <= ARC_IDLE;
          end
        end
        default: state_q <= ARC_IDLE;
      endcase
    end
  end

  // convert request: software set wins over the hardware drop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_q <= 1'b0;
    end else if (wr_ctrl && reg_wdata[`ARC_CTRL_GO]) begin
      go_q <= 1'b1;
    end else if (done) begin
      go_q <= keep_go;
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_repeat_enable_q  <= 1'b0;
      soi_q   <= 1'b0;
      double_sample_enable_q  <= 1'b0;
      previous_source_select_q  <= 1'b0;
      sub_q   <= 1'b0;
      mode_q  <= `ARC_MD_BASIC;
      shift_q <= 3'h0;
      error_select_a_q  <= 3'h0;
      tmd_q   <= `ARC_TMD_NEVER;
      rpt_q   <= `ARC_RPT_RST;
      setpt_q <= 16'h0000;
      uth_q   <= 16'h0000;
      lth_q   <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        auto_repeat_enable_q <= reg_wdata[`ARC_CTRL_AUTO_REPEAT_ENABLE];
        soi_q  <= reg_wdata[`ARC_CTRL_SOI];
        double_sample_enable_q <= reg_wdata[`ARC_CTRL_DOUBLE_SAMPLE_ENABLE];
        previous_source_select_q <= reg_wdata[`ARC_CTRL_PREVIOUS_SOURCE_SELECT];
        sub_q  <= reg_wdata[`ARC_CTRL_SUB];
      end
      if (wr_mode) begin
        mode_q  <= reg_wdata[`ARC_MODE_MD +: 3];
        shift_q <= reg_wdata[`ARC_MODE_SHIFT +: 3];
        error_select_a_q  <= reg_wdata[`ARC_MODE_ERROR_SELECT_A +: 3];
        tmd_q   <= reg_wdata[`ARC_MODE_TMD +: 3];
      end
      if (reg_we && (reg_addr == `ARC_OFF_RPT)) begin
        rpt_q <= reg_wdata[7:0];
      end
      if (reg_we && (reg_addr == `ARC_OFF_SETPT)) begin
        setpt_q <= reg_wdata[15:0];
      end
      if (reg_we && (reg_addr == `ARC_OFF_UTH)) begin
        uth_q <= reg_wdata[15:0];
      end
      if (reg_we && (reg_addr == `ARC_OFF_LTH)) begin
        lth_q <= reg_wdata[15:0];
      end
    end
  end

  // clear request counts out the slow-clock delay before acting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_req_q <= 1'b0;
      clr_cnt_q <= 3'h0;
    end else if (clr_fire) begin
      clr_req_q <= 1'b0;
      clr_cnt_q <= 3'h0;
    end else if (clr_req_q) begin
      clr_cnt_q <= clr_cnt_q + 3'h1;
    end else if (wr_ctrl && reg_wdata[`ARC_CTRL_ACCUM_CLEAR_REQUEST]) begin
      clr_req_q <= 1'b1;
    end
  end

  // accumulator, count and overflow; basic mode leaves them alone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 18'h00000;
      cnt_q <= 8'h00;
      ovf_q <= 1'b0;
      flt_q <= 18'h00000;
    end else if (clr_fire) begin
      acc_q <= 18'h00000;
      cnt_q <= 8'h00;
      ovf_q <= 1'b0;
    end else if (done && filt_mode) begin
      acc_q <= acc_d_c;
      cnt_q <= cnt_c;
      ovf_q <= ovf_next;
      flt_q <= flt_c;
    end
  end

  // sample sequencing and results
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b0;
      hold_q  <= 10'h000;
      res_q   <= 10'h000;
      prev_q  <= 18'h00000;
      err_q   <= 18'h00000;
      upper_cross_status_q  <= 1'b0;
      lower_cross_status_q  <= 1'b0;
    end else if (done) begin
      if (first_smp) begin
        first_q <= 1'b1;
        hold_q  <= conv_result;
      end else begin
        first_q <= 1'b0;
        prev_q  <= previous_source_select_q ? flt_q : {8'h00, (double_sample_enable_q ? hold_q : res_q)};
        res_q   <= conv_result;
        err_q   <= err_c[17:0];
        upper_cross_status_q  <= above_u;
        lower_cross_status_q  <= below_l;
      end
    end else if (!double_sample_enable_q) begin
      first_q <= 1'b0;
    end
  end

  // channel flag: a hit in the same cycle as a software clear wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (done && hit) begin
      flag_q <= 1'b1;
    end else if (wr_stat && reg_wdata[`ARC_STAT_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  assign channel_threshold_irq = flag_q;

  // read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      `ARC_OFF_CTRL:  rd_c = {25'h0000000, sub_q, previous_source_select_q, clr_req_q, double_sample_enable_q, soi_q, auto_repeat_enable_q, go_q};
      `ARC_OFF_MODE:  rd_c = {17'h00000, tmd_q, 1'b0, error_select_a_q, 1'b0, shift_q, 1'b0, mode_q};
      `ARC_OFF_STAT:  rd_c = {27'h0000000, flag_q, lower_cross_status_q, upper_cross_status_q, first_q, ovf_q};
      `ARC_OFF_RPT:   rd_c = {24'h000000, rpt_q};
      `ARC_OFF_CNT:   rd_c = {24'h000000, cnt_q};
      `ARC_OFF_ACC:   rd_c = {14'h0000, acc_q};
      `ARC_OFF_FLT:   rd_c = {14'h0000, flt_q};
      `ARC_OFF_ERR:   rd_c = {{14{err_q[17]}}, err_q};
      `ARC_OFF_SETPT: rd_c = {{16{setpt_q[15]}}, setpt_q};
      `ARC_OFF_UTH:   rd_c = {{16{uth_q[15]}}, uth_q};
      `ARC_OFF_LTH:   rd_c = {{16{lth_q[15]}}, lth_q};
      `ARC_OFF_RES:   rd_c = {22'h000000, res_q};
      `ARC_OFF_PREV:  rd_c = {14'h0000, prev_q};
      default:        rd_c = 32'h00000000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h00000000;
    end else begin
      reg_rdata_q <= reg_re ? rd_c : 32'h00000000;
    end
  end

  assign reg_rdata = reg_rdata_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_clear_begin;
    $rose(clr_req_q);
  endsequence

  sequence s_clear_end;
    ##[1:5] $fell(clr_req_q);
  endsequence

  a_clear_bounded: assert property (s_clear_begin |-> s_clear_end)
    else $error("accumulator clear overran five cycles");

  a_clear_zeroes: assert property ($fell(clr_req_q) |-> (acc_q == 18'h00000) && (cnt_q == 8'h00) && !ovf_q)
    else $error("clear left accumulator state behind");

  a_count_step: assert property (done && filt_mode && !clr_fire && !restart && (cnt_q != 8'hFF)
                                 |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("sample count did not step by one");

  a_basic_holds: assert property (done && (mode_q == `ARC_MD_BASIC) && !clr_fire |=> $stable(acc_q))
    else $error("basic mode changed the accumulator");

  a_ovf_irq: assert property (done && eval && ovf_next |=> flag_q)
    else $error("overflow did not raise the channel flag");

  a_always_irq: assert property (done && eval && (tmd_q == `ARC_TMD_ALWAYS) |=> flag_q ##1 flag_q || $past(wr_stat))
    else $error("always test did not set the flag");

  a_first_quiet: assert property (done && first_smp && !flag_q |=> !flag_q && first_q && $stable(err_q))
    else $error("first sample touched error or flag");

  a_soi_stop: assert property (done && soi_q && hit && !wr_ctrl |=> !go_q ##1 (state_q == ARC_IDLE))
    else $error("stop on interrupt did not halt conversions");

  a_auto_repeat_enable_retrig: assert property (done && auto_repeat_enable_q && !(soi_q && hit) && !clr_req_q |=> go_q && conv_start)
    else $error("auto repeat did not retrigger");

endmodule

// >>> include/arc_consts.svh
/*
  Offsets, field positions, reset values and counts of the computation unit.
  Assumes a 100 MHz ref_clk and a register port with an 8-bit byte address.
*/
// Function
// - each trigger adds or subtracts the result in the accumulator; overflow past 262143 flags.
// - sample count increments for every sample added to the accumulator; here it holds at 255.
// - count reaching the repeat target may auto-clear the accumulator, per mode.
// - clear request empties accumulator, overflow flag and count; hardware then drops the request.
// - the accumulator clear may take up to five converter clock cycles.
// - result shift right-shifts the accumulator into the filtered value; 1..6 set cutoff.
// - basic mode does no accumulation but keeps threshold, double sampling, repeat.
// - accumulate mode adds each result, updates filtered value, always tests thresholds.
// - accumulator and filtered value are always right-justified.
// - average mode accumulates every sample, tests thresholds once count reaches target.
// - burst average retriggers until count equals target, even without auto repeat.
// - low-pass mode filters samples, tests thresholds once count reaches target.
// - error value computed by one of six selectable difference calculations.
// - error compared with upper and lower thresholds sets the cross status bits.
// - threshold test picks one of eight conditions; a hit sets the channel flag.
// - all threshold comparisons are signed two's complement.
// - overflow flag set always signals a threshold interrupt; here only on samples that run the threshold test.
// - auto repeat keeps convert request set and retriggers after each update.
// - stop-on-interrupt clears convert request on a threshold hit.
// - double sampling takes two conversions per error calculation; repeat chains them.
// - first conversion sets first-sample flag only; second stores, computes error and flag.
// - double-sample cycle uses previous result as first sample, current as second.
`ifndef ARC_CONSTS_SVH
`define ARC_CONSTS_SVH

// register byte offsets
`define ARC_OFF_CTRL     8'h00
`define ARC_OFF_MODE     8'h04
`define ARC_OFF_STAT     8'h08
`define ARC_OFF_RPT      8'h0C
`define ARC_OFF_CNT      8'h10
`define ARC_OFF_ACC      8'h14
`define ARC_OFF_FLT      8'h18
`define ARC_OFF_ERR      8'h1C
`define ARC_OFF_SETPT    8'h20
`define ARC_OFF_UTH      8'h24
`define ARC_OFF_LTH      8'h28
`define ARC_OFF_RES      8'h2C
`define ARC_OFF_PREV     8'h30

// control register fields
`define ARC_CTRL_GO      0
`define ARC_CTRL_AUTO_REPEAT_ENABLE    1
`define ARC_CTRL_SOI     2
`define ARC_CTRL_DOUBLE_SAMPLE_ENABLE    3
`define ARC_CTRL_ACCUM_CLEAR_REQUEST    4
`define ARC_CTRL_PREVIOUS_SOURCE_SELECT    5
`define ARC_CTRL_SUB     6

// mode register fields (low bit of each 3-bit field)
`define ARC_MODE_MD      0
`define ARC_MODE_SHIFT   4
`define ARC_MODE_ERROR_SELECT_A    8
`define ARC_MODE_TMD     12

// status register fields
`define ARC_STAT_OVF     0
`define ARC_STAT_FIRST   1
`define ARC_STAT_UPPER_CROSS_STATUS    2
`define ARC_STAT_LOWER_CROSS_STATUS    3
`define ARC_STAT_FLAG    4

// compute modes
`define ARC_MD_BASIC     3'h0
`define ARC_MD_ACCUM     3'h1
`define ARC_MD_AVG       3'h2
`define ARC_MD_BURST     3'h3
`define ARC_MD_LPF       3'h4

// threshold tests
`define ARC_TMD_NEVER    3'h0
`define ARC_TMD_ALWAYS   3'h7

// reset values and counts
`define ARC_RPT_RST      8'h00
`define ARC_CLR_CYCLES   3'h5
`define ARC_CNT_MAX      8'hFF

`endif

// >>> include/arc_pkg.sv
/*
  Types shared by the computation unit.
  Assumes arc_consts.svh holds every number.
*/
package arc_pkg;
  typedef logic [7:0]  arc_addr_t;
  typedef logic [31:0] arc_word_t;
  typedef logic [9:0]  arc_res_t;
  typedef enum logic [0:0] {
    ARC_IDLE,
    ARC_CONV
  } arc_state_t;
endpackage

// >>> test/arc_core_model.sv
/*
  Behavioural converter core facing the computation unit.
  Assumes conv_start is a one-cycle request on ref_clk; the bench queues results in q
  and picks the answer delay in lat (1 or more cycles).
*/
`timescale 1ns/1ps

module arc_core_model (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              conv_start,
  output logic                   conv_done,
  output arc_pkg::arc_res_t      conv_result
);
  import arc_pkg::*;
  arc_res_t q[$];
  int       lat      = 1;
  int       conv_cnt = 0;
  int       left     = 0;
  bit       busy     = 1'b0;

  initial begin
    conv_done   = 1'b0;
    conv_result = 10'h2AA;
  end

  // one conversion per start; result lines churn outside the done cycle so nothing stale passes
  always @(posedge ref_clk) begin
    conv_done   <= 1'b0;
    conv_result <= ~conv_result;
    if (busy) begin
      if (left == 0) begin
        conv_done   <= 1'b1;
        conv_result <= (q.size() > 0) ? q.pop_front() : 10'h000;
        conv_cnt++;
        busy = 1'b0;
      end else begin
        left--;
      end
    end else if (rst_n && conv_start) begin
      busy = 1'b1;
      left = lat - 1;
    end
  end
endmodule

// >>> test/arc_unit_test.sv
/*
  Self-checking bench of the computation unit: register tasks and scenario sequence.
  Assumes arc_core_model answers the conversions and the register map of arc_consts.svh.
*/
`timescale 1ns/1ps
`include "arc_consts.svh"

module arc_unit_test;
  import arc_pkg::*;
  logic      ref_clk;
  logic      rst_n;
  arc_addr_t reg_addr;
  arc_word_t reg_wdata;
  logic      reg_we;
  logic      reg_re;
  arc_word_t reg_rdata;
  logic      ext_trigger;
  logic      conv_start;
  logic      conv_done;
  arc_res_t  conv_result;
  logic      channel_threshold_irq;
  int        errors;
  int        tests_run;
  int        e;
  arc_word_t rv;

  arc_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .ext_trigger(ext_trigger),
    .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
    .channel_threshold_irq(channel_threshold_irq));

  arc_core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .conv_start(conv_start),
    .conv_done(conv_done), .conv_result(conv_result));

  // free-running 100 MHz clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  task automatic chk(input string n, input arc_word_t x, input arc_word_t g);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one-cycle strobes, driven just after the edge
  task automatic wr(input arc_addr_t a, input arc_word_t d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge ref_clk);
    reg_we    <= 1'b0;
  endtask

  task automatic rd(input arc_addr_t a, output arc_word_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge ref_clk);
    reg_re   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input arc_addr_t a, input arc_word_t m, input arc_word_t x, input string n);
    arc_word_t d;
    rd(a, d);
    chk(n, x, d & m);
  endtask

  // start once by control write, or by the external trigger when c is zero, then wait for n conversions
  task automatic run(input arc_word_t c, input int n);
    int t;
    t = core.conv_cnt + n;
    if (c == 32'h0) begin
      @(posedge ref_clk);
      ext_trigger <= 1'b1;
      @(posedge ref_clk);
      ext_trigger <= 1'b0;
    end else begin
      wr(`ARC_OFF_CTRL, c);
    end
    for (int i = 0; i < 400 && core.conv_cnt < t; i++) @(posedge ref_clk);
    chk("conv_count", arc_word_t'(t), arc_word_t'(core.conv_cnt));
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic accum_clear_request;
    wr(`ARC_OFF_CTRL, 32'h0000_0010);
    repeat (6) @(posedge ref_clk);
    wr(`ARC_OFF_STAT, 32'h0000_0010);
  endtask

  // expected hit of the threshold test for lower -10, upper 10
  function automatic logic hit(input int m, input int v);
    case (m)
      0: return 1'b0;
      1: return v < -10;
      2: return v >= -10;
      3: return v >= -10 && v <= 10;
      4: return v < -10 || v > 10;
      5: return v <= 10;
      6: return v > 10;
      default: return 1'b1;
    endcase
  endfunction

  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (30000) @(posedge ref_clk);
    errors++;
    test_done();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    ext_trigger = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rchk(`ARC_OFF_CTRL, 32'hFFFF_FFFF, 32'h0, "ctrl_rst");
    rchk(8'h40, 32'hFFFF_FFFF, 32'h0, "unmapped");
    chk("irq_rst", 32'h0, {31'h0, channel_threshold_irq});
    // accumulate mode, shift 1
    wr(`ARC_OFF_MODE, 32'h0000_0011);
    core.q.push_back(10'h064);
    core.q.push_back(10'h0C8);
    run(32'h1, 1);
    run(32'h1, 1);
    rchk(`ARC_OFF_ACC, 32'hFFFF_FFFF, 32'h12C, "acc_sum");
    rchk(`ARC_OFF_CNT, 32'hFFFF_FFFF, 32'h2, "cnt_sum");
    rchk(`ARC_OFF_FLT, 32'hFFFF_FFFF, 32'h96, "flt_shift");
    // software clear, busy while running
    wr(`ARC_OFF_CTRL, 32'h0000_0010);
    rchk(`ARC_OFF_CTRL, 32'h0000_0010, 32'h10, "clr_busy");
    repeat (6) @(posedge ref_clk);
    rchk(`ARC_OFF_ACC, 32'hFFFF_FFFF, 32'h0, "acc_clr");
    rchk(`ARC_OFF_CNT, 32'hFFFF_FFFF, 32'h0, "cnt_clr");
    rchk(`ARC_OFF_CTRL, 32'hFFFF_FFFF, 32'h0, "clr_done");
    // basic mode, external trigger, result minus setpoint
    wr(`ARC_OFF_MODE, 32'h0000_7200);
    wr(`ARC_OFF_SETPT, 32'h0000_0032);
    wr(`ARC_OFF_UTH, 32'h0000_000A);
    wr(`ARC_OFF_LTH, 32'hFFFF_FFF6);
    core.lat = 6;
    core.q.push_back(10'h064);
    run(32'h0, 1);
    rchk(`ARC_OFF_RES, 32'hFFFF_FFFF, 32'h64, "res");
    rchk(`ARC_OFF_ERR, 32'hFFFF_FFFF, 32'h32, "err_setpt");
    rchk(`ARC_OFF_ACC, 32'hFFFF_FFFF, 32'h0, "acc_basic");
    rchk(`ARC_OFF_STAT, 32'h0000_001F, 32'h14, "stat_basic");
    chk("irq_set", 32'h1, {31'h0, channel_threshold_irq});
    wr(`ARC_OFF_STAT, 32'h0000_0010);
    #1;
    chk("irq_clr", 32'h0, {31'h0, channel_threshold_irq});
    // every threshold test against a negative, zero and positive error
    core.lat = 1;
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 3; k++) begin
        e = 20 * k - 20;
        wr(`ARC_OFF_MODE, arc_word_t'(m) << `ARC_MODE_TMD | 32'h0000_0200);
        core.q.push_back(arc_res_t'(30 + 20 * k));
        run(32'h1, 1);
        rchk(`ARC_OFF_STAT, 32'h1C, {27'h0, hit(m, e), e < -10, e > 10, 2'b00}, "stat_thr");
        chk("irq_thr", {31'h0, hit(m, e)}, {31'h0, channel_threshold_irq});
        wr(`ARC_OFF_STAT, 32'h0000_0010);
      end
    end
    // subtract below zero: overflow, interrupt although the test is never
    wr(`ARC_OFF_MODE, 32'h0000_0001);
    core.q.push_back(10'h001);
    run(32'h41, 1);
    rchk(`ARC_OFF_STAT, 32'h0000_0001, 32'h1, "ovf");
    chk("irq_ovf", 32'h1, {31'h0, channel_threshold_irq});
    accum_clear_request();
    rchk(`ARC_OFF_STAT, 32'h0000_0011, 32'h0, "ovf_clr");
    // low-pass, shift 1, target 2
    wr(`ARC_OFF_MODE, 32'h0000_7014);
    wr(`ARC_OFF_RPT, 32'h0000_0002);
    core.q.push_back(10'h064);
    core.q.push_back(10'h064);
    run(32'h1, 1);
    rchk(`ARC_OFF_FLT, 32'hFFFF_FFFF, 32'h32, "lpf_flt1");
    rchk(`ARC_OFF_STAT, 32'h0000_0010, 32'h0, "lpf_early");
    run(32'h1, 1);
    rchk(`ARC_OFF_ACC, 32'hFFFF_FFFF, 32'h96, "lpf_acc");
    rchk(`ARC_OFF_FLT, 32'hFFFF_FFFF, 32'h4B, "lpf_flt2");
    rchk(`ARC_OFF_STAT, 32'h0000_0010, 32'h10, "lpf_hit");
    accum_clear_request();
    // burst average from one start, then average restarts the sum
    wr(`ARC_OFF_MODE, 32'h0000_7023);
    wr(`ARC_OFF_RPT, 32'h0000_0004);
    for (int i = 1; i <= 4; i++) core.q.push_back(arc_res_t'(10 * i));
    run(32'h1, 4);
    rchk(`ARC_OFF_CNT, 32'hFFFF_FFFF, 32'h4, "burst_cnt");
    rchk(`ARC_OFF_FLT, 32'hFFFF_FFFF, 32'h19, "burst_avg");
    rchk(`ARC_OFF_CTRL, 32'h0000_0001, 32'h0, "burst_stop");
    rchk(`ARC_OFF_STAT, 32'h0000_0010, 32'h10, "burst_hit");
    wr(`ARC_OFF_STAT, 32'h0000_0010);
    wr(`ARC_OFF_MODE, 32'h0000_7022);
    core.q.push_back(10'h008);
    run(32'h1, 1);
    rchk(`ARC_OFF_ACC, 32'hFFFF_FFFF, 32'h8, "avg_restart");
    rchk(`ARC_OFF_CNT, 32'hFFFF_FFFF, 32'h1, "avg_cnt");
    rchk(`ARC_OFF_STAT, 32'h0000_0010, 32'h0, "avg_early");
    // auto repeat keeps go; stop-on-interrupt ends it
    wr(`ARC_OFF_MODE, 32'h0000_0000);
    core.lat = 6;
    run(32'h3, 3);
    rchk(`ARC_OFF_CTRL, 32'h0000_0003, 32'h3, "auto_repeat_enable_go");
    wr(`ARC_OFF_MODE, 32'h0000_7000);
    wr(`ARC_OFF_CTRL, 32'h0000_0006);
    for (int i = 0; i < 50; i++) begin
      rd(`ARC_OFF_CTRL, rv);
      if (rv[0] === 1'b0) break;
    end
    chk("soi_stop", 32'h6, rv);
    wr(`ARC_OFF_CTRL, 32'h0000_0000);
    wr(`ARC_OFF_STAT, 32'h0000_0010);
    // double sample: first holds, second computes second minus first
    core.lat = 1;
    wr(`ARC_OFF_MODE, 32'h0000_7100);
    core.q.push_back(10'h12C);
    run(32'h9, 1);
    rchk(`ARC_OFF_STAT, 32'h0000_0012, 32'h2, "ds_first");
    core.q.push_back(10'h064);
    run(32'h9, 1);
    rchk(`ARC_OFF_ERR, 32'hFFFF_FFFF, 32'hFFFF_FF38, "ds_err");
    rchk(`ARC_OFF_PREV, 32'hFFFF_FFFF, 32'h12C, "ds_prev");
    rchk(`ARC_OFF_RES, 32'hFFFF_FFFF, 32'h64, "ds_res");
    rchk(`ARC_OFF_STAT, 32'h0000_0010, 32'h10, "ds_hit");
    rchk(`ARC_OFF_CTRL, 32'h0000_0001, 32'h0, "ds_go_done");
    // double sample with auto repeat: one start runs both, the hit stops it
    core.q.push_back(10'h0C8);
    core.q.push_back(10'h064);
    run(32'hF, 2);
    rchk(`ARC_OFF_ERR, 32'hFFFF_FFFF, 32'hFFFF_FF9C, "ds_auto_repeat_enable_err");
    rchk(`ARC_OFF_CTRL, 32'h0000_0001, 32'h0, "ds_auto_repeat_enable_stop");
    // filtered-based errors; previous register takes the old filtered value
    accum_clear_request();
    wr(`ARC_OFF_MODE, 32'h0000_0301);
    core.q.push_back(10'h050);
    run(32'h21, 1);
    rchk(`ARC_OFF_ERR, 32'hFFFF_FFFF, 32'h0, "err_res_flt");
    wr(`ARC_OFF_MODE, 32'h0000_0401);
    core.q.push_back(10'h014);
    run(32'h21, 1);
    rchk(`ARC_OFF_ERR, 32'hFFFF_FFFF, 32'h14, "err_flt_der");
    rchk(`ARC_OFF_PREV, 32'hFFFF_FFFF, 32'h50, "prev_flt");
    wr(`ARC_OFF_MODE, 32'h0000_0501);
    core.q.push_back(10'h01E);
    run(32'h21, 1);
    rchk(`ARC_OFF_ERR, 32'hFFFF_FFFF, 32'h50, "err_flt_setpt");
    test_done();
  end
endmodule
